// file: src/sem_pkg.sv
package sem_pkg;
    // register placement and bit layout of the serial control register
    localparam logic [7:0] CTRL_ADDR = 8'h40;
    localparam logic CTRL_BANK = 1'h1;
    localparam int CS_BIT = 4;
    localparam int SK_BIT = 5;
    localparam int DI_BIT = 6;
    localparam int DO_BIT = 7;
    localparam logic [3:0] UNUSED_BITS = 4'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // array geometry
    localparam int WORDS = 128;
    localparam int AW = 7;
    localparam int DW = 8;
    localparam logic [DW-1:0] ERASED_WORD = 8'hFF;
    localparam logic [AW-1:0] ADDR_STEP = 7'h01;

    // bit counting: nine bits after the start bit, eight per data byte
    localparam logic [3:0] CMD_LAST = 4'h8;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;

    // opcodes and special sub-commands
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_SPECIAL = 2'h0;
    localparam logic [1:0] SUB_EN = 2'h3;
    localparam logic [1:0] SUB_DIS = 2'h0;
    localparam logic [1:0] SUB_ERASE_ALL_CMD = 2'h2;
    localparam logic [1:0] SUB_WRITE_ALL_CMD = 2'h1;

    // programming cycle time: longest time, so the count rounds down
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_NS = 2000000;
    localparam int PROG_CYC_DEFAULT = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 19;
    localparam logic [TMR_W-1:0] TMR_ZERO = 19'h00000;
    localparam logic [TMR_W-1:0] TMR_STEP = 19'h00001;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_CMD = 6'h02,
        ST_READ = 6'h04,
        ST_DATA = 6'h08,
        ST_HOLD = 6'h10,
        ST_BUSY = 6'h20
    } sem_state_type;

    typedef enum logic [2:0] {
        PEND_NONE = 3'h0,
        PEND_ERASE = 3'h1,
        PEND_WRITE = 3'h2,
        PEND_ERASE_ALL_CMD = 3'h3,
        PEND_WRITE_ALL_CMD = 3'h4,
        PEND_EN = 3'h5,
        PEND_DIS = 3'h6
    } sem_pend_type;
endpackage : sem_pkg

// file: src/sem_eeprom.sv
// Function
// - array holds 128 bytes, reached only through indirect bank 1 access
// - control bits four to seven, low four zero
// - instruction: start, two opcode, seven address
// - input bit captured at serial clock rise
// - data out high while select low
// - programming disabled at power on
// - enable holds until disable or power loss
// - read gives zero dummy then eight bits
// - read works whether enabled or not
// - read address increments and wraps
// - erase starts at select falling edge
// - data out low while busy, then high
// - write starts at select fall after data
// - word write erases target automatically
// - erase all sets every bit one
// - write all stores byte everywhere
// - word programming completes within two milliseconds
// - opcode and special sub-command encoding
`timescale 1ns/10ps
module sem_eeprom #(
    parameter int PROG_CYC = sem_pkg::PROG_CYC_DEFAULT
) (
    input wire logic sys_clk_i, // system clock
    input wire logic rst_n_i, // power-on reset, active low
    input wire logic [7:0] reg_addr_i, // data memory address of the access
    input wire logic reg_bank_i, // bank select of the access
    input wire logic reg_indirect_i, // access made through the second pointer
    input wire logic reg_wr_i, // write strobe
    input wire logic reg_rd_i, // read strobe
    input wire logic [7:0] reg_wdata_i, // write data
    output logic [7:0] reg_rdata_o, // read data, registered
    output logic busy_o, // programming cycle running
    output logic prog_en_o // programming enabled
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [sem_pkg::DW-1:0] mem [sem_pkg::WORDS];
    sem_pkg::sem_state_type state;
    sem_pkg::sem_pend_type pend;
    logic ctrl_cs, ctrl_sk, ctrl_di, do_line;
    logic sk_prev, cs_prev, prog_en, read_bit;
    logic [3:0] bit_cnt;
    logic [8:0] cmd_sr;
    logic [sem_pkg::DW-1:0] data_sr, out_sr;
    logic [sem_pkg::AW-1:0] addr;
    logic [sem_pkg::TMR_W-1:0] tmr;
    logic reg_sel, sk_rise, cs_fall, busy_done, prog_req;
    logic [8:0] cmd_next;
    logic [1:0] op;
    logic [1:0] sub;
    logic [sem_pkg::AW-1:0] cmd_addr;

    ////////////////////////////////////////////////////////////////////////
    // decode and edge terms; the lines are register bits on this clock,
    // so no synchroniser is needed in front of the edge detectors
    assign reg_sel = reg_indirect_i && (reg_bank_i == sem_pkg::CTRL_BANK)
                     && (reg_addr_i == sem_pkg::CTRL_ADDR);
    assign sk_rise = ctrl_sk && !sk_prev && ctrl_cs;
    assign cs_fall = !ctrl_cs && cs_prev;
    assign cmd_next = {cmd_sr[7:0], ctrl_di};
    assign op = cmd_next[8:7];
    assign sub = cmd_next[6:5];
    assign cmd_addr = cmd_next[6:0];
    assign busy_done = (state == sem_pkg::ST_BUSY)
                       && (tmr == sem_pkg::TMR_W'(PROG_CYC - 1));
    assign prog_req = (pend == sem_pkg::PEND_ERASE) || (pend == sem_pkg::PEND_WRITE)
                      || (pend == sem_pkg::PEND_ERASE_ALL_CMD) || (pend == sem_pkg::PEND_WRITE_ALL_CMD);

    ////////////////////////////////////////////////////////////////////////
    // control register: cs, sk, di writable, do read-only
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_cs <= 1'b0;
            ctrl_sk <= 1'b0;
            ctrl_di <= 1'b0;
        end else if (reg_wr_i && reg_sel) begin
            ctrl_cs <= reg_wdata_i[sem_pkg::CS_BIT];
            ctrl_sk <= reg_wdata_i[sem_pkg::SK_BIT];
            ctrl_di <= reg_wdata_i[sem_pkg::DI_BIT];
        end
    end

    // read data; unused low nibble always zero
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= sem_pkg::RDATA_IDLE;
        end else if (reg_rd_i && reg_sel) begin
            reg_rdata_o <= {do_line, ctrl_di, ctrl_sk, ctrl_cs, sem_pkg::UNUSED_BITS};
        end else begin
            reg_rdata_o <= sem_pkg::RDATA_IDLE;
        end
    end

    // previous line levels for edge detection
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sk_prev <= 1'b0;
            cs_prev <= 1'b0;
        end else begin
            sk_prev <= ctrl_sk;
            cs_prev <= ctrl_cs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial state machine; a deselect mid-instruction aborts it, and the host
    // must drop select between instructions, as hold and read are left only on deselect
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= sem_pkg::ST_IDLE;
            pend <= sem_pkg::PEND_NONE;
            bit_cnt <= sem_pkg::CNT_ZERO;
            cmd_sr <= 9'h000;
            data_sr <= 8'h00;
            out_sr <= 8'h00;
            addr <= 7'h00;
            read_bit <= 1'b1;
        end else begin
            case (state)
                sem_pkg::ST_IDLE: begin
                    pend <= sem_pkg::PEND_NONE;
                    if (sk_rise && ctrl_di) begin
                        state <= sem_pkg::ST_CMD;
                        bit_cnt <= sem_pkg::CNT_ZERO;
                    end
                end
                sem_pkg::ST_CMD: begin
                    if (!ctrl_cs) begin
                        state <= sem_pkg::ST_IDLE;
                    end else if (sk_rise) begin
                        cmd_sr <= cmd_next;
                        bit_cnt <= bit_cnt + sem_pkg::CNT_STEP;
                        if (bit_cnt == sem_pkg::CMD_LAST) begin
                            addr <= cmd_addr;
                            bit_cnt <= sem_pkg::CNT_ZERO;
                            case (op)
                                sem_pkg::OP_READ: begin
                                    state <= sem_pkg::ST_READ;
                                    out_sr <= mem[cmd_addr];
                                    read_bit <= 1'b0;
                                end
                                sem_pkg::OP_ERASE: begin
                                    state <= sem_pkg::ST_HOLD;
                                    pend <= sem_pkg::PEND_ERASE;
                                end
                                sem_pkg::OP_WRITE: begin
                                    state <= sem_pkg::ST_DATA;
                                    pend <= sem_pkg::PEND_WRITE;
                                end
                                default: begin
                                    case (sub)
                                        sem_pkg::SUB_EN: begin
                                            state <= sem_pkg::ST_HOLD;
                                            pend <= sem_pkg::PEND_EN;
                                        end
                                        sem_pkg::SUB_DIS: begin
                                            state <= sem_pkg::ST_HOLD;
                                            pend <= sem_pkg::PEND_DIS;
                                        end
                                        sem_pkg::SUB_ERASE_ALL_CMD: begin
                                            state <= sem_pkg::ST_HOLD;
                                            pend <= sem_pkg::PEND_ERASE_ALL_CMD;
                                        end
                                        default: begin
                                            state <= sem_pkg::ST_DATA;
                                            pend <= sem_pkg::PEND_WRITE_ALL_CMD;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                end
                sem_pkg::ST_READ: begin
                    if (!ctrl_cs) begin
                        state <= sem_pkg::ST_IDLE;
                        read_bit <= 1'b1;
                    end else if (sk_rise) begin
                        read_bit <= out_sr[sem_pkg::DW-1];
                        bit_cnt <= bit_cnt + sem_pkg::CNT_STEP;
                        out_sr <= {out_sr[sem_pkg::DW-2:0], 1'b0};
                        if (bit_cnt == sem_pkg::DATA_LAST) begin
                            // sequential read rolls over the top of the array
                            bit_cnt <= sem_pkg::CNT_ZERO;
                            addr <= addr + sem_pkg::ADDR_STEP;
                            out_sr <= mem[addr + sem_pkg::ADDR_STEP];
                        end
                    end
                end
                sem_pkg::ST_DATA: begin
                    if (!ctrl_cs) begin
                        state <= sem_pkg::ST_IDLE;
                    end else if (sk_rise) begin
                        data_sr <= {data_sr[sem_pkg::DW-2:0], ctrl_di};
                        bit_cnt <= bit_cnt + sem_pkg::CNT_STEP;
                        if (bit_cnt == sem_pkg::DATA_LAST) begin
                            state <= sem_pkg::ST_HOLD;
                        end
                    end
                end
                sem_pkg::ST_HOLD: begin
                    // extra clocks after the instruction are ignored
                    if (cs_fall) begin
                        if (prog_req && prog_en) begin
                            state <= sem_pkg::ST_BUSY;
                        end else begin
                            state <= sem_pkg::ST_IDLE;
                        end
                    end
                end
                sem_pkg::ST_BUSY: begin
                    if (busy_done) begin
                        state <= sem_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= sem_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // programming enable latch, cleared only by reset or disable
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_en <= 1'b0;
        end else if ((state == sem_pkg::ST_HOLD) && cs_fall) begin
            if (pend == sem_pkg::PEND_EN) begin
                prog_en <= 1'b1;
            end else if (pend == sem_pkg::PEND_DIS) begin
                prog_en <= 1'b0;
            end
        end
    end

    // internal cycle timer, runs only while busy
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr <= sem_pkg::TMR_ZERO;
        end else if (state == sem_pkg::ST_BUSY) begin
            tmr <= tmr + sem_pkg::TMR_STEP;
        end else begin
            tmr <= sem_pkg::TMR_ZERO;
        end
    end

    // array update at the end of the timed cycle; write overwrites the
    // whole byte, so no separate erase is needed; contents keep no reset
    always_ff @(posedge sys_clk_i) begin
        if (busy_done) begin
            case (pend)
                sem_pkg::PEND_ERASE: mem[addr] <= sem_pkg::ERASED_WORD;
                sem_pkg::PEND_WRITE: mem[addr] <= data_sr;
                sem_pkg::PEND_ERASE_ALL_CMD: begin
                    for (int i = 0; i < sem_pkg::WORDS; i++) begin
                        mem[i] <= sem_pkg::ERASED_WORD;
                    end
                end
                sem_pkg::PEND_WRITE_ALL_CMD: begin
                    for (int i = 0; i < sem_pkg::WORDS; i++) begin
                        mem[i] <= data_sr;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // data out line and status outputs
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            do_line <= 1'b1;
            busy_o <= 1'b0;
            prog_en_o <= 1'b0;
        end else begin
            busy_o <= (state == sem_pkg::ST_BUSY);
            prog_en_o <= prog_en;
            if (!ctrl_cs) begin
                do_line <= 1'b1;
            end else if (state == sem_pkg::ST_BUSY) begin
                do_line <= 1'b0;
            end else if (state == sem_pkg::ST_READ) begin
                do_line <= read_bit;
            end else begin
                do_line <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [sem_pkg::AW-1:0] chk_addr;
    logic [sem_pkg::DW-1:0] chk_data;
    assign chk_addr = addr;
    assign chk_data = data_sr;

    sequence s_hold_deselect;
        (state == sem_pkg::ST_HOLD) && cs_fall;
    endsequence
    sequence s_last_addr_bit;
        (state == sem_pkg::ST_CMD) && ctrl_cs && sk_rise && (bit_cnt == sem_pkg::CMD_LAST);
    endsequence

    property p_unused_zero;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        reg_rdata_o[3:0] == sem_pkg::UNUSED_BITS;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

    property p_do_high_deselect;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !ctrl_cs |=> do_line;
    endproperty
    a_do_high_deselect: assert property (p_do_high_deselect) else $error("do not high");

    property p_busy_low;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == sem_pkg::ST_BUSY) && ctrl_cs |=> !do_line;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("do not low while busy");

    property p_locked;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_hold_deselect and (!prog_en && prog_req) |=> state == sem_pkg::ST_IDLE;
    endproperty
    a_locked: assert property (p_locked) else $error("program ran while disabled");

    property p_disable;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_hold_deselect and (pend == sem_pkg::PEND_DIS) |=> !prog_en ##1 !prog_en_o;
    endproperty
    a_disable: assert property (p_disable) else $error("disable not taken");

    property p_read_dummy;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_last_addr_bit and (op == sem_pkg::OP_READ)
            |=> (state == sem_pkg::ST_READ) && !read_bit;
    endproperty
    a_read_dummy: assert property (p_read_dummy) else $error("no dummy zero");

    property p_start_bit;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == sem_pkg::ST_IDLE) && sk_rise && !ctrl_di |=> state == sem_pkg::ST_IDLE;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("zero taken as start");

    property p_addr_inc;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (state == sem_pkg::ST_READ) && ctrl_cs && sk_rise && (bit_cnt == sem_pkg::DATA_LAST)
            |=> addr == $past(addr) + sem_pkg::ADDR_STEP;
    endproperty
    a_addr_inc: assert property (p_addr_inc) else $error("read address not stepped");

    property p_busy_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(busy_o) |-> busy_o [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy too short");

    property p_write_word;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        busy_done && (pend == sem_pkg::PEND_WRITE)
            |=> mem[$past(chk_addr)] == $past(chk_data);
    endproperty
    a_write_word: assert property (p_write_word) else $error("word not written");

    property p_erase_all;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        busy_done && (pend == sem_pkg::PEND_ERASE_ALL_CMD)
            |=> (mem[0] == sem_pkg::ERASED_WORD) && (mem[sem_pkg::WORDS-1] == sem_pkg::ERASED_WORD);
    endproperty
    a_erase_all: assert property (p_erase_all) else $error("array not erased");

endmodule : sem_eeprom

// file: bench/sem_host.sv
`timescale 1ns/10ps
module sem_host (
    input wire logic sys_clk_i, // bench clock
    output logic [7:0] addr_o, // access address
    output logic bank_o, // bank select
    output logic ind_o, // indirect access flag
    output logic wr_o, // write strobe
    output logic rd_o, // read strobe
    output logic [7:0] wdata_o, // write data
    output logic chk_o // read result goes to the monitor
);
    integer seed;

    // idle bus at time zero
    initial begin
        seed = 28;
        addr_o = 8'h00;
        bank_o = 1'b0;
        ind_o = 1'b0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
        chk_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // random byte for data, addresses and ignored control bits
    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction : rnd

    // one access; released data is inverted so a stale value never matches,
    // idle cycles stretch the serial clock to an 80 ns period
    task automatic acc(input logic w, input logic c, input logic [7:0] a,
            input logic [7:0] v, input logic [1:0] m);
        @(posedge sys_clk_i);
        addr_o <= a;
        {bank_o, ind_o} <= m;
        wr_o <= w;
        rd_o <= !w;
        chk_o <= c;
        wdata_o <= v;
        @(posedge sys_clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        chk_o <= 1'b0;
        wdata_o <= ~v;
        repeat (6) @(posedge sys_clk_i);
    endtask : acc

    // drive the three serial lines; bit 7 and the low nibble carry junk
    task automatic lines(input logic cs, input logic sk, input logic di);
        logic [7:0] j;
        j = rnd();
        acc(1'b1, 1'b0, sem_pkg::CTRL_ADDR, {j[7], di, sk, cs, j[3:0]}, 2'h3);
    endtask : lines

    // one bit: clock low then high with data held
    task automatic sbit(input logic b);
        lines(1'b1, 1'b0, b);
        lines(1'b1, 1'b1, b);
    endtask : sbit

    // start bit, opcode and address, msb first
    task automatic cmd(input logic [1:0] op, input logic [6:0] a);
        logic [9:0] f;
        f = {1'b1, op, a};
        for (int i = 9; i >= 0; i--) begin
            sbit(f[i]);
        end
    endtask : cmd

    // data byte, msb first
    task automatic sbyte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            sbit(d[i]);
        end
    endtask : sbyte
endmodule : sem_host

// file: bench/test_serial_eeprom_data_memory.sv
`timescale 1ns/10ps
module test_serial_eeprom_data_memory;
    // short programming time keeps the run brief
    localparam int PCYC = 60;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic bank, ind, wr, rd, chk, busy, pen;
    logic chk_d = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] v1, v2, w;
    integer err_total = 0;
    integer samples_checked = 0;

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    sem_host host (.sys_clk_i(sys_clk), .addr_o(addr), .bank_o(bank), .ind_o(ind),
        .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .chk_o(chk));

    sem_eeprom #(.PROG_CYC(PCYC)) dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .reg_addr_i(addr), .reg_bank_i(bank), .reg_indirect_i(ind), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .busy_o(busy),
        .prog_en_o(pen));

    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // register read data compare
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk8

    // status flag compare
    task automatic chk1(input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk1

    // note the expected byte, then issue a read for the monitor
    task automatic note_rd(input logic [7:0] e, input logic [7:0] a, input logic [1:0] m);
        exp_q.push_back(e);
        host.acc(1'b0, 1'b1, a, 8'h00, m);
    endtask : note_rd

    // expected control register with select and clock high
    task automatic see_do(input logic d, input logic di);
        note_rd({d, di, 2'h3, 4'h0}, sem_pkg::CTRL_ADDR, 2'h3);
    endtask : see_do

    task automatic end_cmd();
        host.lines(1'b0, 1'b0, 1'b0);
    endtask : end_cmd

    // timed cycle: data out low while busy, high after, bounded wait
    task automatic wait_prog();
        int n;
        n = 0;
        end_cmd();
        chk1(1'b1, busy);
        // raise select and the clock in one write: the status reads then match see_do,
        // and the clock edge is ignored while the timed cycle runs
        host.lines(1'b1, 1'b1, 1'b0);
        see_do(1'b0, 1'b0);
        while (busy === 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        chk1(1'b1, n < PCYC);
        see_do(1'b1, 1'b0);
        end_cmd();
    endtask : wait_prog

    task automatic special(input logic [1:0] sub);
        logic [7:0] r;
        r = host.rnd();
        host.cmd(sem_pkg::OP_SPECIAL, {sub, r[4:0]});
    endtask : special

    task automatic wr_word(input logic [6:0] a, input logic [7:0] d);
        host.cmd(sem_pkg::OP_WRITE, a);
        host.sbyte(d);
        wait_prog();
    endtask : wr_word

    // one word of a read stream after the dummy bit
    task automatic rd_word(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            host.sbit(1'b0);
            see_do(d[i], 1'b0);
        end
    endtask : rd_word

    task automatic rd_at(input logic [6:0] a, input logic [7:0] d);
        host.cmd(sem_pkg::OP_READ, a);
        see_do(1'b0, a[0]);
        rd_word(d);
    endtask : rd_at

    ////////////////////////////////////////////////////////////////////////////
    // monitor: a checked read answers one cycle after its strobe
    always @(posedge sys_clk) begin
        if (chk_d) begin
            chk8(exp_q.pop_front(), rdata);
        end
        chk_d <= rd & chk;
    end

    // watchdog, well beyond the expected run length
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        stop_test();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        w = host.rnd();
        v1 = host.rnd();
        v2 = host.rnd();
        note_rd(8'h80, sem_pkg::CTRL_ADDR, 2'h3);
        note_rd(8'h00, 8'h41, 2'h3);
        note_rd(8'h00, sem_pkg::CTRL_ADDR, 2'h2);
        note_rd(8'h00, sem_pkg::CTRL_ADDR, 2'h1);
        host.acc(1'b1, 1'b0, 8'h41, 8'h10, 2'h3);
        note_rd(8'h80, sem_pkg::CTRL_ADDR, 2'h3);
        // programming is off after power-on
        wr_word_off: begin
            host.cmd(sem_pkg::OP_WRITE, 7'h05);
            host.sbyte(v1);
            end_cmd();
        end
        chk1(1'b0, busy);
        chk1(1'b0, pen);
        host.sbit(1'b0);
        host.sbit(1'b0);
        special(sem_pkg::SUB_EN);
        end_cmd();
        chk1(1'b1, pen);
        special(sem_pkg::SUB_ERASE_ALL_CMD);
        wait_prog();
        rd_at(7'h03, sem_pkg::ERASED_WORD);
        end_cmd();
        special(sem_pkg::SUB_WRITE_ALL_CMD);
        host.sbyte(w);
        wait_prog();
        wr_word(7'h00, v1);
        wr_word(7'h7F, v2);
        rd_at(7'h7F, v2);
        rd_word(v1);
        rd_word(w);
        end_cmd();
        host.cmd(sem_pkg::OP_ERASE, 7'h00);
        wait_prog();
        rd_at(7'h00, sem_pkg::ERASED_WORD);
        end_cmd();
        special(sem_pkg::SUB_DIS);
        end_cmd();
        chk1(1'b0, pen);
        host.cmd(sem_pkg::OP_ERASE, 7'h05);
        end_cmd();
        chk1(1'b0, busy);
        rd_at(7'h05, w);
        end_cmd();
        stop_test();
    end
endmodule : test_serial_eeprom_data_memory
